// ===== verilog/pia_pkg.sv
// shared constants and carriers for the priority interrupt arbiter
package pia_pkg;
  // ---------------------------------------------------------------
  // levels, codes and reset values
  // ---------------------------------------------------------------
  localparam int NLINE = 7;
  localparam logic [2:0] FC_CPU_SPACE = 3'h7;
  localparam logic [2:0] MASK_ALL = 3'h7;
  localparam logic [2:0] MASK_NONE = 3'h0;
  localparam logic [2:0] MASK_RST = 3'h7;
  localparam logic [2:0] LVL_NMI = 3'h7;
  localparam logic [19:0] ACK_ADDR_HI = 20'hfffff;
  localparam logic ACK_ADDR_LSB = 1'h1;
  localparam logic [3:0] ARBITRATION_ID_FIELD_IM_RST = 4'hf;
  localparam logic [3:0] ARBITRATION_ID_FIELD_MOD_RST = 4'h0;
  localparam logic [3:0] ARBITRATION_ID_FIELD_NONE = 4'h0;
  // vector numbers: plain defaults, not taken from any part
  localparam logic [7:0] AUTOVEC_BASE = 8'h18;
  localparam logic [7:0] SPURIOUS_VEC = 8'h0f;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int BUS_TMO_NS = 1600;
  // longest wait rounds down
  localparam int BUS_TMO_CYC = BUS_TMO_NS / CLK_NS;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] fc;
    logic [23:0] addr;
  } pia_ack_t;
  typedef struct packed {
    logic req;
    logic [2:0] lvl;
    logic [7:0] vec;
  } pia_src_t;
endpackage

// ===== verilog/pia_arbiter.sv
// interrupt recognition, acknowledge and arbitration for the core

// Functional notes
// - mask blocks levels up to mask, not seven
// - mask loaded from acknowledge address level
// - seven lines, line seven highest priority
// - lines wired-nor, internal never drives pins
// - pins 6-1 level, pin 7 edge plus level
// - nmi per assertion and mask leaving 111
// - request valid after two consecutive samples
// - pending request taken only at boundary
// - pending level never stored, highest wins
// - ack: cpu space, high address, level, one
// - equal level resolved by highest arbitration id
// - zero arbitration id winner gives spurious
// - integration id resets 1111, others 0000
// - always contend, no contender gives spurious vector
// - chip selects only on external acknowledge
// - tick timer beats external at equal level
// - edge pins not requests, edge served last
// - end by vector, autovector or bus error
// - stack, clear page field, vector to pc
module pia_arbiter #(
  parameter int NMOD = 4,
  parameter int TMO = pia_pkg::BUS_TMO_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic [6:0] i_irq_pin_n,
  input wire logic [6:0] i_edge_sel,
  input wire pia_pkg::pia_src_t i_tick,
  input wire pia_pkg::pia_src_t i_edge,
  input wire pia_pkg::pia_src_t [NMOD-1:0] i_mod,
  input wire logic [NMOD:0] i_arbitration_id_field_we,
  input wire logic [3:0] i_arbitration_id_field_wd,
  input wire logic i_mask_we,
  input wire logic [2:0] i_mask_wd,
  input wire logic i_boundary,
  input wire logic i_data_size_ack_n,
  input wire logic i_autovector_request_n,
  input wire logic i_bus_error_signal_n,
  input wire logic [7:0] i_data,
  output logic [2:0] o_mask,
  output logic [6:0] o_lines,
  output logic o_pending,
  output logic o_stack,
  output logic o_pk_clr,
  output logic o_iack,
  output pia_pkg::pia_ack_t o_ack,
  output logic o_ext_bus,
  output logic o_cs_en,
  output logic o_spurious,
  output logic [7:0] o_vec_num,
  output logic [15:0] o_vec_addr,
  output logic o_pc_load
);
  localparam int TMO_B = TMO + 3;
  typedef enum logic [2:0] {
    ST_IDLE, ST_STACK, ST_ACK, ST_EXT, ST_DONE
  } pia_state_t;
  // highest set line as a level, zero when none
  function automatic logic [2:0] hi_lvl(input logic [6:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int k = 0; k < 7; k++) begin
      if (v[k]) begin
        r = 3'(k + 1);
      end
    end
    return r;
  endfunction
  // ---------------------------------------------------------------
  // pin synchronisers and validity
  // ---------------------------------------------------------------
  logic [17:0] sy1, sy2;
  logic [6:0] seen;
  logic [6:0] ext_valid;
  logic data_size_ack, autovector_request, bus_error_signal;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sy1 <= 18'h3ffff;
      sy2 <= 18'h3ffff;
    end else if (i_ce) begin
      sy1 <= {i_data, i_bus_error_signal_n, i_autovector_request_n, i_data_size_ack_n, i_irq_pin_n};
      sy2 <= sy1;
    end
  end
  // one extra sample: asserted on two successive periods
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seen <= 7'h00;
    end else if (i_ce) begin
      seen <= ~sy2[6:0];
    end
  end
  assign ext_valid = ~sy2[6:0] & seen & ~i_edge_sel;
  assign data_size_ack = ~sy2[7];
  assign autovector_request = ~sy2[8];
  assign bus_error_signal = ~sy2[9];
  // ---------------------------------------------------------------
  // wired-nor of request lines
  // ---------------------------------------------------------------
  logic [6:0] lines;
  logic [6:0] int_lines;
  always_comb begin
    int_lines = 7'h00;
    if (i_tick.req && i_tick.lvl != 3'h0) begin
      int_lines[i_tick.lvl - 3'h1] = 1'b1;
    end
    if (i_edge.req && i_edge.lvl != 3'h0) begin
      int_lines[i_edge.lvl - 3'h1] = 1'b1;
    end
    for (int m = 0; m < NMOD; m++) begin
      if (i_mod[m].req && i_mod[m].lvl != 3'h0) begin
        int_lines[i_mod[m].lvl - 3'h1] = 1'b1;
      end
    end
  end
  // internal requests join here only, never the pin path
  assign lines = ext_valid | int_lines;
  assign o_lines = lines;
  // ---------------------------------------------------------------
  // mask, nmi detection and pending level
  // ---------------------------------------------------------------
  pia_state_t state;
  logic [2:0] mask, mask_d, ack_lvl;
  logic line7_d, nmi;
  logic [2:0] mlvl, pend_lvl;
  logic nmi_set, nmi_clr;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mask <= pia_pkg::MASK_RST;
    end else if (i_ce) begin
      if (state == ST_ACK) begin
        mask <= o_ack.addr[3:1];
      end else if (i_mask_we) begin
        mask <= i_mask_wd;
      end
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mask_d <= pia_pkg::MASK_RST;
      line7_d <= 1'b0;
    end else if (i_ce) begin
      mask_d <= mask;
      line7_d <= lines[6];
    end
  end
  assign nmi_set = (lines[6] && !line7_d) ||
    (lines[6] && mask_d == pia_pkg::MASK_ALL &&
     mask != pia_pkg::MASK_ALL);
  assign nmi_clr = state == ST_ACK && ack_lvl == pia_pkg::LVL_NMI;
  // a new edge in the clearing cycle is kept
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      nmi <= 1'b0;
    end else if (i_ce) begin
      if (nmi_set) begin
        nmi <= 1'b1;
      end else if (nmi_clr) begin
        nmi <= 1'b0;
      end
    end
  end
  // recomputed every cycle so a later higher level wins
  assign mlvl = hi_lvl({1'b0, lines[5:0]});
  always_comb begin
    if (nmi) begin
      pend_lvl = pia_pkg::LVL_NMI;
    end else if (mlvl > mask) begin
      pend_lvl = mlvl;
    end else begin
      pend_lvl = 3'h0;
    end
  end
  assign o_pending = pend_lvl != 3'h0;
  assign o_mask = mask;
  // ---------------------------------------------------------------
  // arbitration ids
  // ---------------------------------------------------------------
  logic [3:0] arbitration_id_field [NMOD+1];
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int m = 0; m < NMOD; m++) begin
        arbitration_id_field[m] <= pia_pkg::ARBITRATION_ID_FIELD_MOD_RST;
      end
      arbitration_id_field[NMOD] <= pia_pkg::ARBITRATION_ID_FIELD_IM_RST;
    end else if (i_ce) begin
      for (int m = 0; m <= NMOD; m++) begin
        if (i_arbitration_id_field_we[m]) begin
          arbitration_id_field[m] <= i_arbitration_id_field_wd;
        end
      end
    end
  end
  // ---------------------------------------------------------------
  // contention at the acknowledged level
  // ---------------------------------------------------------------
  logic [3:0] best_id;
  logic any_cont, im_wins, tick_hit, ext_hit, edge_hit;
  logic [7:0] best_vec;
  assign tick_hit = i_tick.req && i_tick.lvl == ack_lvl;
  assign ext_hit = ext_valid[ack_lvl - 3'h1];
  assign edge_hit = i_edge.req && i_edge.lvl == ack_lvl;
  // ties between equal ids are left to software to avoid
  always_comb begin
    best_id = pia_pkg::ARBITRATION_ID_FIELD_NONE;
    best_vec = pia_pkg::SPURIOUS_VEC;
    any_cont = 1'b0;
    im_wins = 1'b0;
    for (int m = 0; m < NMOD; m++) begin
      if (i_mod[m].req && i_mod[m].lvl == ack_lvl) begin
        if (!any_cont || arbitration_id_field[m] > best_id) begin
          best_id = arbitration_id_field[m];
          best_vec = i_mod[m].vec;
        end
        any_cont = 1'b1;
      end
    end
    if (tick_hit || ext_hit || edge_hit) begin
      if (!any_cont || arbitration_id_field[NMOD] > best_id) begin
        best_id = arbitration_id_field[NMOD];
        im_wins = 1'b1;
        // tick, then external, then edge
        best_vec = tick_hit ? i_tick.vec : i_edge.vec;
      end
      any_cont = 1'b1;
    end
  end
  // ---------------------------------------------------------------
  // exception sequence
  // ---------------------------------------------------------------
  logic [$clog2(TMO+1)-1:0] tmo_cnt;
  logic [7:0] vec;
  logic spur;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      ack_lvl <= 3'h0;
      vec <= 8'h00;
      spur <= 1'b0;
    end else if (i_ce) begin
      case (state)
        ST_IDLE: begin
          if (i_boundary && o_pending) begin
            ack_lvl <= pend_lvl;
            state <= ST_STACK;
          end
        end
        ST_STACK: begin
          state <= ST_ACK;
        end
        ST_ACK: begin
          if (!any_cont || best_id == pia_pkg::ARBITRATION_ID_FIELD_NONE) begin
            vec <= pia_pkg::SPURIOUS_VEC;
            spur <= 1'b1;
            state <= ST_DONE;
          end else if (im_wins && !tick_hit && ext_hit) begin
            state <= ST_EXT;
          end else begin
            vec <= best_vec;
            spur <= 1'b0;
            state <= ST_DONE;
          end
        end
        ST_EXT: begin
          if (bus_error_signal || 32'(tmo_cnt) >= TMO) begin
            vec <= pia_pkg::SPURIOUS_VEC;
            spur <= 1'b1;
            state <= ST_DONE;
          end else if (data_size_ack) begin
            vec <= sy2[17:10];
            spur <= 1'b0;
            state <= ST_DONE;
          end else if (autovector_request) begin
            vec <= pia_pkg::AUTOVEC_BASE + 8'(ack_lvl);
            spur <= 1'b0;
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
  // bus monitor for the external acknowledge
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tmo_cnt <= '0;
    end else if (i_ce) begin
      if (state == ST_EXT) begin
        tmo_cnt <= tmo_cnt + 1'b1;
      end else begin
        tmo_cnt <= '0;
      end
    end
  end
  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_stack = state == ST_STACK;
  assign o_pk_clr = state == ST_STACK;
  assign o_iack = state == ST_ACK || state == ST_EXT;
  assign o_ack.fc = pia_pkg::FC_CPU_SPACE;
  assign o_ack.addr = {pia_pkg::ACK_ADDR_HI, ack_lvl,
                       pia_pkg::ACK_ADDR_LSB};
  assign o_ext_bus = state == ST_EXT;
  assign o_cs_en = state == ST_EXT;
  assign o_pc_load = state == ST_DONE;
  assign o_spurious = spur;
  assign o_vec_num = vec;
  assign o_vec_addr = {7'h00, vec, 1'b0};
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_ack_address: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) o_iack |-> o_ack.fc == 3'h7 &&
    o_ack.addr[23:4] == 20'hfffff && o_ack.addr[0] &&
    o_ack.addr[3:1] == ack_lvl)
    else $error("acknowledge address malformed");
  a_mask_from_ack: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) i_ce && state == ST_ACK |=>
    mask == $past(ack_lvl))
    else $error("mask not loaded from level");
  a_stack_first: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) i_ce && state == ST_STACK |=>
    o_iack && !o_stack)
    else $error("acknowledge not after stacking");
  a_nmi_edge: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) i_ce && lines[6] && !line7_d |=> nmi)
    else $error("level seven edge lost");
  a_two_samples: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) ext_valid[0] |-> !sy2[0] && !$past(sy2[0]))
    else $error("request valid too early");
  a_mask_blocks: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) !nmi && mlvl <= mask |-> !o_pending)
    else $error("masked request pending");
  a_take_boundary: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) i_ce && state == ST_IDLE && !i_boundary
    |=> state == ST_IDLE)
    else $error("taken off boundary");
  a_spur_zero: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) i_ce && state == ST_ACK &&
    best_id == 4'h0 |=> o_spurious && o_pc_load)
    else $error("zero id not spurious");
  a_cs_external: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) o_cs_en |-> o_ext_bus && !tick_hit)
    else $error("chip select on internal ack");
  a_ext_bounded: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) $rose(o_ext_bus) |->
    ##[1:TMO_B] o_pc_load)
    else $error("external acknowledge never ends");
  a_tick_first: assert property (@(posedge i_clk)
    disable iff (!i_rst_n) i_ce && state == ST_ACK && im_wins &&
    best_id != 4'h0 && tick_hit |=> !o_ext_bus &&
    o_vec_num == $past(i_tick.vec))
    else $error("tick not ahead of external");
endmodule

// ===== test/pia_partner.sv
// far-side peripheral model that answers external acknowledge cycles
module pia_partner (
  input wire logic i_clk,
  input wire logic i_ext_bus,
  input wire pia_pkg::pia_ack_t i_ack,
  input wire logic [2:0] i_lvl,
  input wire logic [7:0] i_vec,
  input wire logic [1:0] i_mode,
  input wire logic [3:0] i_delay,
  output logic o_data_size_ack_n,
  output logic o_autovector_request_n,
  output logic o_bus_error_signal_n,
  output logic [7:0] o_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  initial begin
    cnt = 4'h0;
    o_data_size_ack_n = 1'b1;
    o_autovector_request_n = 1'b1;
    o_bus_error_signal_n = 1'b1;
    o_data = 8'h00;
  end
  // ---------------------------------------------------------------
  // answer
  // ---------------------------------------------------------------
  // released: terminations float to their pull-ups, data keeps toggling
  // so a stale vector can never be mistaken for a fresh one
  always @(posedge i_clk) begin
    if (i_ext_bus !== 1'b1) begin
      cnt <= 4'h0;
      o_data_size_ack_n <= 1'b1;
      o_autovector_request_n <= 1'b1;
      o_bus_error_signal_n <= 1'b1;
      o_data <= ~o_data;
    end else if (i_ack.fc == pia_pkg::FC_CPU_SPACE &&
                 i_ack.addr[3:1] == i_lvl) begin
      cnt <= cnt + 4'h1;
      if (cnt == i_delay) begin
        case (i_mode)
          2'h0: begin
            o_data <= i_vec;
            o_data_size_ack_n <= 1'b0;
          end
          2'h1: o_autovector_request_n <= 1'b0;
          2'h2: o_bus_error_signal_n <= 1'b0;
          default: ; // too late: never answers
        endcase
      end
    end
  end
endmodule

// ===== test/tb_top.sv
// self-checking bench for the priority interrupt arbiter
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
  $display("Error %0t: got %h exp %h", $time, (a), (b)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk, i_rst_n, i_ce, i_mask_we, i_boundary;
  logic [6:0] i_irq_pin_n, i_edge_sel, o_lines;
  pia_pkg::pia_src_t i_tick, i_edge;
  pia_pkg::pia_src_t [3:0] i_mod;
  logic [4:0] i_arbitration_id_field_we;
  logic [3:0] i_arbitration_id_field_wd, p_delay;
  logic [2:0] i_mask_wd, o_mask, p_lvl;
  logic data_size_ack_n, autovector_request_n, bus_error_signal_n, o_pending, o_stack, o_pk_clr, o_iack;
  logic o_ext_bus, o_cs_en, o_spurious, o_pc_load, saw_ext, saw_stk;
  logic [7:0] data, o_vec_num, pv, v0, v1;
  logic [15:0] o_vec_addr;
  logic [1:0] p_mode;
  pia_pkg::pia_ack_t o_ack;
  logic [12:0] exq[$];
  logic [12:0] e;
  int fails, compares;
  pia_arbiter #(.NMOD(4), .TMO(8)) dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_ce(i_ce), .i_irq_pin_n(i_irq_pin_n), .i_edge_sel(i_edge_sel),
    .i_tick(i_tick), .i_edge(i_edge), .i_mod(i_mod),
    .i_arbitration_id_field_we(i_arbitration_id_field_we), .i_arbitration_id_field_wd(i_arbitration_id_field_wd), .i_mask_we(i_mask_we),
    .i_mask_wd(i_mask_wd), .i_boundary(i_boundary), .i_data_size_ack_n(data_size_ack_n),
    .i_autovector_request_n(autovector_request_n), .i_bus_error_signal_n(bus_error_signal_n), .i_data(data), .o_mask(o_mask),
    .o_lines(o_lines), .o_pending(o_pending), .o_stack(o_stack),
    .o_pk_clr(o_pk_clr), .o_iack(o_iack), .o_ack(o_ack),
    .o_ext_bus(o_ext_bus), .o_cs_en(o_cs_en), .o_spurious(o_spurious),
    .o_vec_num(o_vec_num), .o_vec_addr(o_vec_addr), .o_pc_load(o_pc_load));
  pia_partner peer (.i_clk(i_clk), .i_ext_bus(o_ext_bus), .i_ack(o_ack),
    .i_lvl(p_lvl), .i_vec(pv), .i_mode(p_mode), .i_delay(p_delay),
    .o_data_size_ack_n(data_size_ack_n), .o_autovector_request_n(autovector_request_n), .o_bus_error_signal_n(bus_error_signal_n),
    .o_data(data));
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic end_of_test;
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #10;
  endtask
  task automatic set_mask(input logic [2:0] v);
    i_mask_we = 1'b1;
    i_mask_wd = v;
    tick(1);
    i_mask_we = 1'b0;
    tick(1);
  endtask
  task automatic clr;
    i_mod = '0;
    i_tick = '0;
    i_edge = '0;
    i_irq_pin_n = 7'h7f;
    i_edge_sel = 7'h00;
    tick(4);
  endtask
  // expectation queued first; the watcher pops it at the vector load
  task automatic serve(input logic ext, input logic spur,
                       input logic [2:0] lvl, input logic [7:0] vec);
    int i;
    exq.push_back({ext, spur, lvl, vec});
    i_boundary = 1'b1;
    tick(1);
    i_boundary = 1'b0;
    for (i = 0; i < 60 && exq.size() != 0; i++) tick(1);
    if (exq.size() != 0) begin
      fails++;
      $display("Error %0t: no vector load", $time);
      end_of_test();
    end
    tick(1);
  endtask
  // ---------------------------------------------------------------
  // watcher
  // ---------------------------------------------------------------
  always @(negedge i_clk) begin
    if (o_ext_bus === 1'b1 && o_cs_en === 1'b1) saw_ext = 1'b1;
    if (o_stack === 1'b1 && o_pk_clr === 1'b1) saw_stk = 1'b1;
    if (o_iack === 1'b1 && exq.size() != 0)
      `CHK(o_ack, {pia_pkg::FC_CPU_SPACE, pia_pkg::ACK_ADDR_HI,
                   exq[0][10:8], pia_pkg::ACK_ADDR_LSB})
    if (o_pc_load === 1'b1) begin
      e = (exq.size() != 0) ? exq.pop_front() : 13'h1fff;
      `CHK({saw_ext, o_spurious, o_mask, o_vec_num}, e)
      `CHK(o_vec_addr, {7'h00, e[7:0], 1'b0})
      `CHK(saw_stk, 1'b1)
      saw_ext = 1'b0;
      saw_stk = 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {i_rst_n, i_mask_we, i_boundary, i_arbitration_id_field_we, i_arbitration_id_field_wd} = '0;
    {i_mask_wd, p_lvl, p_mode, p_delay, saw_ext, saw_stk} = '0;
    {fails, compares, pv} = '0;
    i_ce = 1'b1;
    i_mod = '0;
    i_tick = '0;
    i_edge = '0;
    i_irq_pin_n = 7'h7f;
    i_edge_sel = 7'h00;
    pv = 8'($urandom(39347));
    repeat (6) @(posedge i_clk);
    #10 i_rst_n = 1'b1;
    tick(1);
    `CHK(o_mask, pia_pkg::MASK_RST)
    `CHK(o_vec_num, 8'h00)
    i_ce = 1'b0;
    set_mask(pia_pkg::MASK_NONE);
    `CHK(o_mask, pia_pkg::MASK_RST)
    i_ce = 1'b1;
    i_mod[0] = '{1'b1, 3'h6, 8'h40};
    tick(4);
    `CHK(o_pending, 1'b0)
    `CHK(o_lines, 7'h20)
    set_mask(pia_pkg::MASK_NONE);
    `CHK(o_pending, 1'b1)
    tick(5);
    `CHK(o_iack, 1'b0)
    serve(1'b0, 1'b1, 3'h6, pia_pkg::SPURIOUS_VEC);
    `CHK(o_pending, 1'b0)
    clr();
    for (int k = 0; k < 4; k++) begin
      i_arbitration_id_field_we = 5'(1 << k);
      i_arbitration_id_field_wd = 4'(k + 1);
      tick(1);
    end
    i_arbitration_id_field_we = 5'h00;
    // same level on two modules: higher id must win at levels 1 to 6
    for (int l = 1; l < 7; l++) begin
      set_mask(pia_pkg::MASK_NONE);
      v0 = 8'($urandom);
      v1 = 8'($urandom);
      i_mod[0] = '{1'b1, 3'(l), v0};
      i_mod[1] = '{1'b1, 3'(l), v1};
      tick(2);
      serve(1'b0, 1'b0, 3'(l), v1);
      clr();
    end
    set_mask(pia_pkg::MASK_NONE);
    i_mod[0] = '{1'b1, 3'h2, 8'h21};
    tick(2);
    i_mod[2] = '{1'b1, 3'h5, 8'h52};
    tick(2);
    serve(1'b0, 1'b0, 3'h5, 8'h52);
    `CHK(o_pending, 1'b0)
    clr();
    // data_size_ack slow, then autovector, bus error and a silent peripheral
    p_lvl = 3'h4;
    for (int m = 0; m < 4; m++) begin
      set_mask(pia_pkg::MASK_NONE);
      p_mode = 2'(m);
      p_delay = (m == 0) ? 4'h3 : 4'h0;
      pv = 8'($urandom);
      i_irq_pin_n[3] = 1'b0;
      tick(4);
      serve(1'b1, m > 1, 3'h4, (m == 0) ? pv : (m == 1) ?
            pia_pkg::AUTOVEC_BASE + 8'h04 : pia_pkg::SPURIOUS_VEC);
      clr();
    end
    p_mode = 2'h0;
    set_mask(pia_pkg::MASK_NONE);
    i_tick = '{1'b1, 3'h4, 8'h55};
    i_edge = '{1'b1, 3'h4, 8'h66};
    i_irq_pin_n[3] = 1'b0;
    tick(4);
    serve(1'b0, 1'b0, 3'h4, 8'h55);
    i_tick = '0;
    set_mask(pia_pkg::MASK_NONE);
    serve(1'b1, 1'b0, 3'h4, pv);
    clr();
    set_mask(pia_pkg::MASK_NONE);
    i_edge = '{1'b1, 3'h1, 8'h66};
    i_edge_sel[1] = 1'b1;
    i_irq_pin_n[1] = 1'b0;
    tick(4);
    serve(1'b0, 1'b0, 3'h1, 8'h66);
    clr();
    p_lvl = 3'h7;
    set_mask(pia_pkg::MASK_ALL);
    i_irq_pin_n[6] = 1'b0;
    tick(1);
    `CHK(o_pending, 1'b0)
    tick(3);
    `CHK(o_pending, 1'b1)
    serve(1'b1, 1'b0, 3'h7, pv);
    tick(3);
    `CHK(o_pending, 1'b0)
    set_mask(3'h6);
    `CHK(o_pending, 1'b1)
    serve(1'b1, 1'b0, 3'h7, pv);
    clr();
    end_of_test();
  end
endmodule
